// *** hw/rbt_channel.sv ***
/*
 * one transceiver channel: two storage registers, edge detect on the
 * capture clock inputs, registered drive of the a and b ports.
 * assumes capture clock inputs are synchronous to clk_i.
 */
`timescale 1ns/10ps
module rbt_channel #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input rbt_pkg::rbt_ctl_t ctl_i,
  input wire logic ab_cap_i,
  input wire logic ba_cap_i,
  input wire logic [W-1:0] a_in_i,
  input wire logic [W-1:0] b_in_i,
  output logic [W-1:0] a_out_o,
  output logic a_oe_o,
  output logic [W-1:0] b_out_o,
  output logic b_oe_o,
  output logic [W-1:0] ab_q_o,
  output logic [W-1:0] ba_q_o,
  output logic cap_o
);
  import rbt_pkg::*;

  if (W < 1) begin : g_bad_w
    $error("rbt_channel: W must be at least 1");
  end

  logic ab_prev_r, ba_prev_r;         // last capture clock levels
  logic ab_rise, ba_rise;             // capture edges this cycle
  logic [W-1:0] ab_r, ab_nxt;         // a-to-b storage
  logic [W-1:0] ba_r, ba_nxt;         // b-to-a storage
  logic [W-1:0] ao_r, ao_nxt, bo_r, bo_nxt;  // port drive values
  logic aoe_r, aoe_nxt, boe_r, boe_nxt;      // port drive enables
  logic cap_r;                        // a store happened last edge

  // ****************************************
  // capture and drive, next values
  // ****************************************
  always_comb begin
    ab_rise = ab_cap_i && !ab_prev_r;
    ba_rise = ba_cap_i && !ba_prev_r;
    // stores ignore drive enable and direction entirely
    ab_nxt = ab_rise ? a_in_i : ab_r;
    ba_nxt = ba_rise ? b_in_i : ba_r;
    // enables are exclusive by construction
    aoe_nxt = !ctl_i.drive_en_n && !ctl_i.dir;
    boe_nxt = !ctl_i.drive_en_n && ctl_i.dir;
    // mux ahead of a flop: a select change never glitches the pin
    ao_nxt = ctl_i.b_to_a_source_select ? ba_r : b_in_i;
    bo_nxt = ctl_i.a_to_b_source_select ? ab_r : a_in_i;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ab_prev_r <= 1'b1;  // no false edge at reset release
      ba_prev_r <= 1'b1;
      ab_r <= '0;
      ba_r <= '0;
      ao_r <= '0;
      bo_r <= '0;
      aoe_r <= 1'b0;
      boe_r <= 1'b0;
      cap_r <= 1'b0;
    end else begin
      ab_prev_r <= ab_cap_i;
      ba_prev_r <= ba_cap_i;
      ab_r <= ab_nxt;
      ba_r <= ba_nxt;
      ao_r <= ao_nxt;
      bo_r <= bo_nxt;
      aoe_r <= aoe_nxt;
      boe_r <= boe_nxt;
      cap_r <= ab_rise || ba_rise;
    end
  end

  assign a_out_o = ao_r;
  assign a_oe_o = aoe_r;
  assign b_out_o = bo_r;
  assign b_oe_o = boe_r;
  assign ab_q_o = ab_r;
  assign ba_q_o = ba_r;
  assign cap_o = cap_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ab_edge;
    !ab_cap_i ##1 ab_cap_i;
  endsequence

  AST_AB_STORE: assert property (s_ab_edge |=> ab_r == $past(a_in_i))
    else $error("a-side store missed capture edge");
  AST_HOLD_BA: assert property (!(ba_cap_i && !ba_prev_r) |=> $stable(ba_r))
    else $error("b-to-a storage changed without edge");

endmodule : rbt_channel

// *** hw/rbt_fifo.sv ***
/*
 * synchronous fifo with valid/ready on both sides and a fill count.
 * assumes one clock, synchronous active-high reset, depth a power of two.
 */
`timescale 1ns/10ps
module rbt_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  import rbt_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);

  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("rbt_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // storage array
  logic [AW-1:0] wr_r, wr_nxt;    // write pointer
  logic [AW-1:0] rd_r, rd_nxt;    // read pointer
  logic [AW:0] cnt_r, cnt_nxt;    // words held
  logic push, pop;                // accepted transfers

  // ****************************************
  // next pointers and count
  // ****************************************
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem[wr_r] <= in_data_i;  // data needs no reset
    end
  end

  // honest flags straight from the count
  assign in_ready_o = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem[rd_r];
  assign count_o = cnt_r;

  AST_FIFO_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_r <= DEPTH[AW:0]) else $error("fifo count above depth");

endmodule : rbt_fifo

// *** hw/rbt_top.sv ***
/*
 * registered bus transceiver, two 8-bit channels or one 16-bit unit,
 * with a wishbone classic slave for control and a capture log fifo.
 * assumes port inputs and capture clock inputs are synchronous to clk_i
 * and that pad logic resolves pins from the output enables.
 */
// Overview of operation
// - two 8-bit channels, or ganged as sixteen
// - each register stores on its capture rising edge
// - stores happen whatever enable and direction say
// - driving one port, inputs still storable anywhere
// - selects pick live or stored data per direction
// - select change gives no output glitch
// - enabled: direction chooses which bus is driven
// - disabled: no port driven, storage still works
// - a channel never drives both buses at once
// - enabled, dir low, select low: live b onto a
// - enabled, dir low, select high: stored b onto a
// - enabled, dir high, select low: live a onto b
// - enabled, dir high, select high: stored a onto b
`timescale 1ns/10ps
module rbt_top #(
  parameter int unsigned CH_W = rbt_pkg::RBT_CH_W,
  parameter int unsigned LOG_DEPTH = rbt_pkg::RBT_LOG_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] a_to_b_capture_clk_i,
  input wire logic [1:0] b_to_a_capture_clk_i,
  input wire logic [2*CH_W-1:0] port_a_in_i,
  output logic [2*CH_W-1:0] port_a_out_o,
  output logic [1:0] port_a_oe_o,
  input wire logic [2*CH_W-1:0] port_b_in_i,
  output logic [2*CH_W-1:0] port_b_out_o,
  output logic [1:0] port_b_oe_o,
  output logic log_ready_o
);
  import rbt_pkg::*;

  // the log word packs all four stores, so the channel width is fixed
  if (CH_W != RBT_CH_W || LOG_DEPTH != RBT_LOG_DEPTH) begin : g_bad_par
    $error("rbt_top: CH_W and LOG_DEPTH must match the package sizes");
  end

  // ****************************************
  // declarations
  // ****************************************
  logic [8:0] ctrl_r, ctrl_nxt;        // per-channel controls and gang bit
  logic ack_r, ack_nxt;                // bus answer
  logic [31:0] dat_r, dat_nxt;         // bus read data
  logic ovf_r, ovf_nxt;                // sticky: capture log overflowed
  logic lrdy_r;                        // registered log ready
  logic req;                           // new bus request this cycle
  logic wr_ctrl, rd_log, clr_ovf;      // decoded actions
  rbt_ctl_t ctl [RBT_CH_N];            // controls seen by each channel
  logic [1:0] ab_cap, ba_cap;          // capture inputs per channel
  logic [CH_W-1:0] ab_q [RBT_CH_N];    // a-to-b stores
  logic [CH_W-1:0] ba_q [RBT_CH_N];    // b-to-a stores
  logic [1:0] cap;                     // store pulses per channel
  logic [RBT_LOG_W-1:0] log_in;        // snapshot pushed to the log
  logic [RBT_LOG_W-1:0] log_out;       // log head
  logic log_push, log_in_rdy;          // fill side
  logic log_valid;                     // drain side
  logic [RBT_CNT_W-1:0] log_cnt;       // words held

  // ****************************************
  // channel controls, gang mode
  // ****************************************
  // in gang mode channel 1 follows channel 0 controls and clocks
  always_comb begin
    ctl[0] = rbt_ctl_t'(ctrl_r[RBT_CTL_BITS-1:0]);
    ctl[1] = ctrl_r[RBT_GANG_BIT] ? ctl[0]
                                  : rbt_ctl_t'(ctrl_r[2*RBT_CTL_BITS-1:RBT_CTL_BITS]);
    ab_cap[0] = a_to_b_capture_clk_i[0];
    ba_cap[0] = b_to_a_capture_clk_i[0];
    ab_cap[1] = ctrl_r[RBT_GANG_BIT] ? a_to_b_capture_clk_i[0]
                                     : a_to_b_capture_clk_i[1];
    ba_cap[1] = ctrl_r[RBT_GANG_BIT] ? b_to_a_capture_clk_i[0]
                                     : b_to_a_capture_clk_i[1];
  end

  // ****************************************
  // the two channels
  // ****************************************
  for (genvar c = 0; c < RBT_CH_N; c++) begin : g_ch
    rbt_channel #(
      .W(CH_W)
    ) u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ctl_i(ctl[c]),
      .ab_cap_i(ab_cap[c]),
      .ba_cap_i(ba_cap[c]),
      .a_in_i(port_a_in_i[c*CH_W +: CH_W]),
      .b_in_i(port_b_in_i[c*CH_W +: CH_W]),
      .a_out_o(port_a_out_o[c*CH_W +: CH_W]),
      .a_oe_o(port_a_oe_o[c]),
      .b_out_o(port_b_out_o[c*CH_W +: CH_W]),
      .b_oe_o(port_b_oe_o[c]),
      .ab_q_o(ab_q[c]),
      .ba_q_o(ba_q[c]),
      .cap_o(cap[c])
    );
  end

  // ****************************************
  // capture log
  // ****************************************
  // a store pulse pushes the updated snapshot of all four registers;
  // stores are never blocked, so a full log drops the word instead
  assign log_push = |cap;
  assign log_in = {ba_q[1], ab_q[1], ba_q[0], ab_q[0]};

  rbt_fifo #(
    .WIDTH(RBT_LOG_W),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(log_push),
    .in_ready_o(log_in_rdy),
    .in_data_i(log_in),
    .out_valid_o(log_valid),
    .out_ready_i(rd_log),
    .out_data_o(log_out),
    .count_o(log_cnt)
  );

  // ****************************************
  // wishbone slave, next values
  // ****************************************
  // answer one cycle after the request; a request held past its ack is answered again every second cycle
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_r;
    ack_nxt = req;
    wr_ctrl = req && wb_we_i && (wb_adr_i == RBT_OFS_CTRL);
    rd_log = req && !wb_we_i && (wb_adr_i == RBT_OFS_LOG) && log_valid;
    clr_ovf = req && wb_we_i && (wb_adr_i == RBT_OFS_LSTAT) && wb_sel_i[2]
              && wb_dat_i[RBT_OVF_BIT];
    // byte lanes: lane 0 per-channel bits, lane 1 gang bit
    ctrl_nxt = ctrl_r;
    if (wr_ctrl && wb_sel_i[0]) begin
      ctrl_nxt[7:0] = wb_dat_i[7:0];
    end
    if (wr_ctrl && wb_sel_i[1]) begin
      ctrl_nxt[RBT_GANG_BIT] = wb_dat_i[RBT_GANG_BIT];
    end
    // a drop in the clearing cycle keeps the flag set
    ovf_nxt = (log_push && !log_in_rdy) || (ovf_r && !clr_ovf);
    // read mux; unmapped and write cycles answer zero
    dat_nxt = 32'h0000_0000;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        RBT_OFS_CTRL: dat_nxt = {23'h00_0000, ctrl_r};
        RBT_OFS_STORE: dat_nxt = log_in;
        RBT_OFS_LOG: dat_nxt = log_valid ? log_out : 32'h0000_0000;
        RBT_OFS_LSTAT: begin
          dat_nxt[RBT_CNT_W-1:0] = log_cnt;
          dat_nxt[RBT_EMPTY_BIT] = !log_valid;
          dat_nxt[RBT_FULL_BIT] = !log_in_rdy;
          dat_nxt[RBT_OVF_BIT] = ovf_r;
        end
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // wishbone slave, registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= RBT_CTRL_RST;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      ovf_r <= 1'b0;
      lrdy_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ovf_r <= ovf_nxt;
      lrdy_r <= log_in_rdy;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign log_ready_o = lrdy_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ba_edge0;
    !ba_cap[0] ##1 ba_cap[0];
  endsequence

  sequence s_drive_a0(logic sel);
    !ctl[0].drive_en_n && !ctl[0].dir && ctl[0].b_to_a_source_select == sel;
  endsequence

  sequence s_drive_b0(logic sel);
    !ctl[0].drive_en_n && ctl[0].dir && ctl[0].a_to_b_source_select == sel;
  endsequence

  AST_EXCLUSIVE: assert property ((port_a_oe_o & port_b_oe_o) == 2'b00)
    else $error("both buses driven by one channel");
  AST_ISOLATE: assert property (ctl[0].drive_en_n |=> !port_a_oe_o[0] && !port_b_oe_o[0])
    else $error("port driven in isolation");
  AST_DIR_SELECT: assert property (!ctl[1].drive_en_n |=> port_b_oe_o[1] == $past(ctl[1].dir))
    else $error("direction did not pick the driven bus");
  AST_LIVE_B_TO_A: assert property (s_drive_a0(1'b0) |=> port_a_oe_o[0]
    && port_a_out_o[CH_W-1:0] == $past(port_b_in_i[CH_W-1:0]))
    else $error("live b data not on a");
  AST_STORED_B_TO_A: assert property (s_drive_a0(1'b1) |=> port_a_oe_o[0]
    && port_a_out_o[CH_W-1:0] == $past(ba_q[0]))
    else $error("stored b data not on a");
  AST_LIVE_A_TO_B: assert property (s_drive_b0(1'b0) |=> port_b_oe_o[0]
    && port_b_out_o[CH_W-1:0] == $past(port_a_in_i[CH_W-1:0]))
    else $error("live a data not on b");
  AST_STORED_A_TO_B: assert property (s_drive_b0(1'b1) |=> port_b_oe_o[0]
    && port_b_out_o[CH_W-1:0] == $past(ab_q[0]))
    else $error("stored a data not on b");
  AST_STORE_WHILE_DRIVING: assert property (s_ba_edge0 ##0 port_b_oe_o[0]
    |=> ba_q[0] == $past(port_b_in_i[CH_W-1:0]))
    else $error("store blocked while port driven");
  AST_STORE_ISOLATED: assert property (s_ba_edge0 ##0 ctl[0].drive_en_n
    |=> ba_q[0] == $past(port_b_in_i[CH_W-1:0]) && cap[0])
    else $error("isolated store missing or not logged");
  AST_SELECT_NO_GLITCH: assert property ($changed(ctl[0].b_to_a_source_select)
    |=> $stable(port_a_out_o[CH_W-1:0]) || $stable(ctl[0].b_to_a_source_select))
    else $error("output moved more than once on select change");
  AST_GANG_FOLLOW: assert property (ctrl_r[RBT_GANG_BIT] && !ctl[0].drive_en_n
    |=> port_a_oe_o[1] == port_a_oe_o[0] && port_b_oe_o[1] == port_b_oe_o[0])
    else $error("ganged channels disagree");
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !ack_r |=> ack_r ##1 !ack_r)
    else $error("bus answer not a single cycle after request");

  // ****************************************
  // checks on the log, on channel 1 and on a channel 0 select switch
  // ****************************************
  // a push that the full log refuses
  sequence s_log_drop;
    log_push && !log_in_rdy;
  endsequence

  // stores are never blocked, so a lost snapshot must at least be flagged
  AST_OVF_SET: assert property (s_log_drop |=> ovf_r)
    else $error("dropped log word did not set overflow");
  // sticky until software writes a one to it
  AST_OVF_HOLD: assert property (ovf_r && !clr_ovf |=> ovf_r)
    else $error("overflow flag cleared without a write");
  // an accepted snapshot leaves the log non-empty
  AST_LOG_PUSH: assert property (log_push && log_in_rdy |=> log_valid)
    else $error("stored snapshot not logged");
  // channel 1 isolation, whether ganged or not
  AST_ISOLATE_CH1: assert property (ctl[1].drive_en_n
    |=> !port_a_oe_o[1] && !port_b_oe_o[1])
    else $error("channel 1 port driven in isolation");
  // channel 1 live path towards b
  AST_LIVE_A_TO_B_CH1: assert property (!ctl[1].drive_en_n && ctl[1].dir
    && !ctl[1].a_to_b_source_select
    |=> port_b_out_o[2*CH_W-1:CH_W] == $past(port_a_in_i[2*CH_W-1:CH_W]))
    else $error("live a data not on b, channel 1");
  // a switch to stored data lands on the pins in one step, no mixed value
  AST_SELECT_TO_STORED: assert property (s_drive_a0(1'b1)
    ##0 $changed(ctl[0].b_to_a_source_select)
    |=> port_a_out_o[CH_W-1:0] == $past(ba_q[0]))
    else $error("select switch did not land on stored data");

endmodule : rbt_top

// *** inc/rbt_pkg.sv ***
/*
 * shared constants and carrier types of the registered bus transceiver:
 * register offsets, field positions, reset values and sizes.
 * assumes it is compiled before every design file that imports it.
 */
package rbt_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned RBT_CH_W = 8;        // width of one channel
  localparam int unsigned RBT_CH_N = 2;        // channels in the block
  localparam int unsigned RBT_LOG_DEPTH = 16;  // capture log depth in words
  localparam int unsigned RBT_LOG_W = 32;      // one log word, all stores
  localparam int unsigned RBT_CNT_W = 5;       // log fill count width

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] RBT_OFS_CTRL = 8'h00;   // control of both channels
  localparam logic [7:0] RBT_OFS_STORE = 8'h04;  // storage registers, read only
  localparam logic [7:0] RBT_OFS_LOG = 8'h08;    // log head, read pops
  localparam logic [7:0] RBT_OFS_LSTAT = 8'h0C;  // log status, w1c overflow

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned RBT_CTL_BITS = 4;      // control bits per channel
  localparam int unsigned RBT_GANG_BIT = 8;      // ctrl: 16-bit joint mode
  localparam int unsigned RBT_EMPTY_BIT = 8;     // lstat: log empty
  localparam int unsigned RBT_FULL_BIT = 9;      // lstat: log full
  localparam int unsigned RBT_OVF_BIT = 16;      // lstat: capture dropped
  localparam logic [8:0] RBT_CTRL_RST = 9'h0_11; // both channels isolated

  // per-channel controls, lsb first: drive_en_n, dir, a_to_b, b_to_a select
  typedef struct packed {
    logic b_to_a_source_select;  // 1: stored b-side data onto a
    logic a_to_b_source_select;  // 1: stored a-side data onto b
    logic dir;                   // 1: drive b, 0: drive a
    logic drive_en_n;            // 1: isolation, no port driven
  } rbt_ctl_t;

endpackage : rbt_pkg

// *** verification/rbt_bus_model.sv ***
/* far side of both ports: two parallel buses driven by other logic.
   assumes the device raises a channel's drive enable while it drives. */
`timescale 1ns/10ps
module rbt_bus_model #(
  parameter int unsigned W = 8
) (
  input wire logic [1:0] a_oe_i,
  input wire logic [2*W-1:0] a_out_i,
  input wire logic [1:0] b_oe_i,
  input wire logic [2*W-1:0] b_out_i,
  input wire logic [2*W-1:0] a_drv_i,
  input wire logic [2*W-1:0] b_drv_i,
  output logic [2*W-1:0] a_bus_o,
  output logic [2*W-1:0] b_bus_o
);
  // ********
  // bus resolution
  // ********
  // far side lets go of a channel while the device drives it, so no contention
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      a_bus_o[c*W +: W] = a_oe_i[c] ? a_out_i[c*W +: W] : a_drv_i[c*W +: W];
      b_bus_o[c*W +: W] = b_oe_i[c] ? b_out_i[c*W +: W] : b_drv_i[c*W +: W];
    end
  end
endmodule : rbt_bus_model

// *** verification/rbt_top_tb_top.sv ***
/* bench of the bus transceiver: wishbone tasks, random modes, captures, log.
   assumes rbt_pkg, the design files and the bus model are compiled first. */
`timescale 1ns/10ps
module rbt_top_tb_top;
  import rbt_pkg::*;
  localparam int LIMIT = 6000; // cycle ceiling, run needs about 450
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] cap_ab = 2'h0; // capture clocks, idle low
  logic [1:0] cap_ba = 2'h0;
  logic [15:0] pa = 16'h0000; // far side drive values
  logic [15:0] pb = 16'h0000;
  logic [15:0] bus_a, bus_b, out_a, out_b;
  logic [1:0] oe_a, oe_b;
  logic log_ready;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] seed = 16'h003B;
  logic [7:0] st_ab [2] = '{8'h00, 8'h00}; // expected stores
  logic [7:0] st_ba [2] = '{8'h00, 8'h00};
  logic [31:0] logq [$]; // expected log words
  logic ovf_exp = 1'b0;

  always #2.5 clk_i = ~clk_i;

  rbt_top u_rbt_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .a_to_b_capture_clk_i(cap_ab),
    .b_to_a_capture_clk_i(cap_ba), .port_a_in_i(bus_a), .port_a_out_o(out_a),
    .port_a_oe_o(oe_a), .port_b_in_i(bus_b), .port_b_out_o(out_b),
    .port_b_oe_o(oe_b), .log_ready_o(log_ready));

  rbt_bus_model u_rbt_bus_model (
    .a_oe_i(oe_a), .a_out_i(out_a), .b_oe_i(oe_b), .b_out_i(out_b),
    .a_drv_i(pa), .b_drv_i(pb), .a_bus_o(bus_a), .b_bus_o(bus_b));

  // ********
  // helpers
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // expected bus levels and drive of one channel, oe is {b, a}
  function automatic void lvl(input rbt_ctl_t c, input int ch, output logic [7:0] a,
      output logic [7:0] b, output logic [1:0] oe);
    a = pa[ch*8 +: 8];
    b = pb[ch*8 +: 8];
    oe = {!c.drive_en_n & c.dir, !c.drive_en_n & !c.dir};
    if (oe[0]) a = c.b_to_a_source_select ? st_ba[ch] : b;
    if (oe[1]) b = c.a_to_b_source_select ? st_ab[ch] : a;
  endfunction : lvl

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle; waits for ack, bounded only by the cycle ceiling
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    check("wb_lat", n, 2); // answer in the cycle after the request is taken
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // gang mode hands ch0 controls to ch1
  task automatic chk_ports(input logic [8:0] cw);
    rbt_ctl_t c;
    logic [7:0] a, b;
    logic [1:0] oe;
    for (int ch = 0; ch < 2; ch++) begin
      c = (cw[8] || ch == 0) ? cw[3:0] : cw[7:4];
      lvl(c, ch, a, b, oe);
      check("oe_a", oe_a[ch], oe[0]);
      check("oe_b", oe_b[ch], oe[1]);
      check("one_side", oe_a[ch] & oe_b[ch], 0);
      if (oe[0]) check("out_a", out_a[ch*8 +: 8], a);
      if (oe[1]) check("out_b", out_b[ch*8 +: 8], b);
    end
  endtask : chk_ports

  // expected stores take the settled bus level before the rise
  task automatic capture(input logic [8:0] cw, input logic [1:0] cab, input logic [1:0] cba);
    rbt_ctl_t c;
    logic [7:0] a, b;
    logic [1:0] oe, eab, eba;
    eab = cw[8] ? {2{cab[0]}} : cab;
    eba = cw[8] ? {2{cba[0]}} : cba;
    for (int ch = 0; ch < 2; ch++) begin
      c = (cw[8] || ch == 0) ? cw[3:0] : cw[7:4];
      lvl(c, ch, a, b, oe);
      if (eab[ch]) st_ab[ch] = a;
      if (eba[ch]) st_ba[ch] = b;
    end
    if (logq.size() < 16) logq.push_back({st_ba[1], st_ab[1], st_ba[0], st_ab[0]});
    else ovf_exp = 1'b1;
    @(posedge clk_i);
    cap_ab <= cab;
    cap_ba <= cba;
    repeat (2) @(posedge clk_i);
    cap_ab <= 2'h0;
    cap_ba <= 2'h0;
    repeat (3) @(posedge clk_i);
  endtask : capture

  task tally_and_finish;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    logic [31:0] rd;
    logic [8:0] cw;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("oe_rst", {oe_b, oe_a}, 0);
    wb(1'b0, RBT_OFS_CTRL, 4'hF, 0, rd);
    check("ctrl_rst", rd, {23'h00_0000, RBT_CTRL_RST});
    wb(1'b0, RBT_OFS_STORE, 4'hF, 0, rd);
    check("store_rst", rd, 0);
    wb(1'b0, RBT_OFS_LSTAT, 4'hF, 0, rd);
    check("lstat_rst", rd, 32'h0000_0100);
    wb(1'b0, 8'h10, 4'hF, 0, rd);
    check("unmapped", rd, 0);
    // first sixteen passes walk every ch0 mode, ch1 random except in ganged passes, where it follows ch0
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      cw = {(i % 5 == 4), seed[7:4], ((i < 16) ? 4'(i) : seed[3:0])};
      wb(1'b1, RBT_OFS_CTRL, 4'h3, {23'h00_0000, cw}, rd);
      seed = lfsr(seed);
      pa <= seed;
      seed = lfsr(seed);
      pb <= seed;
      repeat (3) @(posedge clk_i);
      chk_ports(cw);
      seed = lfsr(seed);
      capture(cw, seed[1:0], seed[3:2] | 2'h1);
      chk_ports(cw);
      wb(1'b0, RBT_OFS_STORE, 4'hF, 0, rd);
      check("store", rd, {st_ba[1], st_ab[1], st_ba[0], st_ab[0]});
    end
    // log was never drained, so it must have refused words
    wb(1'b0, RBT_OFS_LSTAT, 4'hF, 0, rd);
    check("lstat", rd, {15'h0000, ovf_exp, 6'h00, logq.size() == 16, logq.size() == 0,
      3'h0, 5'(logq.size())});
    check("log_ready", log_ready, logq.size() < 16);
    while (logq.size() > 0) begin
      wb(1'b0, RBT_OFS_LOG, 4'hF, 0, rd);
      check("log", rd, logq.pop_front());
    end
    wb(1'b0, RBT_OFS_LOG, 4'hF, 0, rd);
    check("log_empty", rd, 0);
    wb(1'b1, RBT_OFS_LSTAT, 4'h4, 32'h0001_0000, rd);
    wb(1'b0, RBT_OFS_LSTAT, 4'hF, 0, rd);
    check("lstat_clr", rd, 32'h0000_0100);
    wb(1'b1, RBT_OFS_STORE, 4'hF, 32'hFFFF_FFFF, rd);
    wb(1'b0, RBT_OFS_STORE, 4'hF, 0, rd);
    check("store_ro", rd, {st_ba[1], st_ab[1], st_ba[0], st_ab[0]});
    tally_and_finish();
  end
endmodule : rbt_top_tb_top
